// ==== acc_pkg.sv ====
// Purpose: Shared constants for the analog comparator control block.
// Assumes: APB with 32-bit data; one control/status register word.
// Notes:   Field positions follow the control register layout.
package acc_pkg;

	localparam int unsigned ADDR_W            = 12;
	localparam int unsigned DATA_W            = 32;

	// Byte address of the control/status word.
	localparam logic [11:0] CSR_OFFSET        = 12'h000;

	// Field positions inside the control/status word.
	localparam int unsigned ENABLE_BIT        = 7;
	localparam int unsigned REF_SEL_BIT       = 6;
	localparam int unsigned FLAG_BIT          = 5;
	localparam int unsigned IRQ_EN_BIT        = 4;
	localparam int unsigned READBACK_BIT      = 3;
	localparam int unsigned PIN_EN_BIT        = 2;
	localparam int unsigned EDGE_SEL_MSB      = 1;
	localparam int unsigned EDGE_SEL_LSB      = 0;

	// Reset value of the control/status word.
	localparam logic [7:0]  CSR_RESET         = 8'h00;

	// Edge select encodings.
	localparam logic [1:0]  EDGE_FALL_A       = 2'h0;
	localparam logic [1:0]  EDGE_RISE         = 2'h1;
	localparam logic [1:0]  EDGE_FALL_B       = 2'h2;
	localparam logic [1:0]  EDGE_BOTH         = 2'h3;

endpackage : acc_pkg

// ==== acc_comparator_ctrl.sv ====
// Purpose: Digital control around an analog comparator, reached over APB.
// Assumes: Comparator output is asynchronous to pclk; mode inputs are not needed.
// Notes:   Zero wait state slave; unmapped addresses answer with pslverr.
//
// Overview of operation
// - Enable bit 7 switches the whole comparator function on or off; disabling leaves the flag and irq unchanged.
// - Bit 6 picks the positive pin or the bandgap as non-inverting input.
// - Bit 5 flag sets on the chosen compare event; cleared by writing one.
// - Interrupt request is flag and interrupt enable bit 4.
// - Bit 3 reads the live comparator output; zero at reset and when disabled.
// - Bit 2 drives the result onto the output pin only while enabled.
// - Edge select: 00 falling, 01 rising, 10 falling, 11 either edge.
// - Keeps comparing in wait and can wake the processor by interrupt.
// - Keeps comparing in stop and keeps driving the output pin.
// - In stop a compare event sets the flag and wakes with interrupt enabled.
// - A reset leaving stop returns all control and status to reset values.
// - Operation continues unchanged during active background debug.
// - Negative input pin always feeds the inverting input.
// - Result is high when non-inverting input exceeds the inverting input.
//
// Chosen here: the APB interface to the registers and the address map.
`timescale 1ns/10ps

module acc_comparator_ctrl
(
	input  wire logic        pclk,              // APB clock, 50 MHz
	input  wire logic        presetn,           // Asynchronous reset, active low
	input  wire logic        psel,              // APB select
	input  wire logic        penable,           // APB access phase
	input  wire logic        pwrite,            // APB direction, high for write
	input  wire logic [11:0] paddr,             // APB byte address
	input  wire logic [31:0] pwdata,            // APB write data
	output logic      [31:0] prdata,            // APB read data
	output logic             pready,            // APB ready
	output logic             pslverr,           // APB error on unmapped address
	input  wire logic        cmp_result_async,  // Raw analog comparator result
	output logic             cmp_power_en,      // Powers the analog comparator
	output logic             bandgap_sel,       // High: bandgap on non-inverting input
	output logic             pos_pin_sel,       // High: positive pin on non-inverting input
	output logic             neg_pin_sel,       // High: negative pin on inverting input
	output logic             comparator_out_pin,    // Digital output pin level
	output logic             comparator_out_pin_oe, // Output pin drive enable
	output logic             irq                // Interrupt and wakeup request
);

	// Register state.
	logic        enable_ff;
	logic        ref_sel_ff;
	logic        flag_ff;
	logic        irq_en_ff;
	logic        pin_en_ff;
	logic [1:0]  edge_sel_ff;
	logic        sync1_ff;
	logic        sync2_ff;
	logic        prev_ff;
	logic        armed_ff;
	logic        pin_ff;
	logic        pin_oe_ff;
	logic [31:0] prdata_ff;

	// Next values.
	logic        nxt_enable;
	logic        nxt_ref_sel;
	logic        nxt_flag;
	logic        nxt_irq_en;
	logic        nxt_pin_en;
	logic [1:0]  nxt_edge_sel;
	logic        nxt_pin;
	logic        nxt_pin_oe;
	logic [31:0] nxt_prdata;

	// Decode and event terms.
	logic        addr_hit;
	logic        setup_any;
	logic        setup_rd;
	logic        wr_access;
	logic        clear_req;
	logic        live_level;
	logic        rise;
	logic        fall;
	logic        event_hit;
	logic        event_ok;
	logic [7:0]  csr_view;

	assign addr_hit  = (paddr[11:2] == acc_pkg::CSR_OFFSET[11:2]);
	assign setup_any = psel & ~penable;
	assign setup_rd  = setup_any & ~pwrite & addr_hit;
	assign wr_access = psel & penable & pwrite & addr_hit;
	assign clear_req = wr_access & pwdata[acc_pkg::FLAG_BIT];

	// Zero wait state; every access completes in its first access cycle.
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~addr_hit;
	assign prdata  = prdata_ff;

	// Control fields load only on a mapped write and hold otherwise.
	// Nothing here watches wait, stop or debug, so the block keeps running
	// through all of them.
	always_comb
	begin
		nxt_enable   = enable_ff;
		nxt_ref_sel  = ref_sel_ff;
		nxt_irq_en   = irq_en_ff;
		nxt_pin_en   = pin_en_ff;
		nxt_edge_sel = edge_sel_ff;
		if (wr_access)
		begin
			nxt_enable   = pwdata[acc_pkg::ENABLE_BIT];
			nxt_ref_sel  = pwdata[acc_pkg::REF_SEL_BIT];
			nxt_irq_en   = pwdata[acc_pkg::IRQ_EN_BIT];
			nxt_pin_en   = pwdata[acc_pkg::PIN_EN_BIT];
			nxt_edge_sel = pwdata[acc_pkg::EDGE_SEL_MSB:acc_pkg::EDGE_SEL_LSB];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			enable_ff <= acc_pkg::CSR_RESET[acc_pkg::ENABLE_BIT];
		end
		else
		begin
			enable_ff <= nxt_enable;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ref_sel_ff <= acc_pkg::CSR_RESET[acc_pkg::REF_SEL_BIT];
		end
		else
		begin
			ref_sel_ff <= nxt_ref_sel;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq_en_ff <= acc_pkg::CSR_RESET[acc_pkg::IRQ_EN_BIT];
		end
		else
		begin
			irq_en_ff <= nxt_irq_en;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pin_en_ff <= acc_pkg::CSR_RESET[acc_pkg::PIN_EN_BIT];
		end
		else
		begin
			pin_en_ff <= nxt_pin_en;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			edge_sel_ff <= acc_pkg::CSR_RESET[acc_pkg::EDGE_SEL_MSB:acc_pkg::EDGE_SEL_LSB];
		end
		else
		begin
			edge_sel_ff <= nxt_edge_sel;
		end
	end

	// Two-flop synchroniser; only the second stage is read by other logic.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sync1_ff <= 1'b0;
		end
		else
		begin
			sync1_ff <= cmp_result_async;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sync2_ff <= 1'b0;
		end
		else
		begin
			sync2_ff <= sync1_ff;
		end
	end

	// The history flop tracks the synchronised level even while disabled, and
	// detection is armed one cycle after enable, but turning the comparator on
	// with the result high sets the flag in modes 01 and 11 once sync2_ff rises.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prev_ff <= 1'b0;
		end
		else
		begin
			prev_ff <= sync2_ff;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			armed_ff <= 1'b0;
		end
		else
		begin
			armed_ff <= enable_ff;
		end
	end

	assign live_level = sync2_ff;
	assign rise       = live_level & ~prev_ff;
	assign fall       = ~live_level & prev_ff;

	always_comb
	begin
		event_hit = 1'b0;
		case (edge_sel_ff)
			acc_pkg::EDGE_FALL_A:
			begin
				event_hit = fall;
			end
			acc_pkg::EDGE_RISE:
			begin
				event_hit = rise;
			end
			acc_pkg::EDGE_FALL_B:
			begin
				event_hit = fall;
			end
			acc_pkg::EDGE_BOTH:
			begin
				event_hit = rise | fall;
			end
			default:
			begin
				event_hit = 1'b0;
			end
		endcase
	end

	// An edge only counts once the comparator has been on for a full cycle.
	assign event_ok = enable_ff & armed_ff & event_hit;

	// A new event in the same cycle as a write-one clear keeps the flag set.
	always_comb
	begin
		nxt_flag = flag_ff;
		if (event_ok)
			nxt_flag = 1'b1;
		else if (clear_req)
			nxt_flag = 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			flag_ff <= acc_pkg::CSR_RESET[acc_pkg::FLAG_BIT];
		end
		else
		begin
			flag_ff <= nxt_flag;
		end
	end

	// Output pin follows the synchronised result, so it lags the analog edge
	// by the synchroniser depth plus one flop.
	always_comb
	begin
		nxt_pin    = sync2_ff & enable_ff & pin_en_ff;
		nxt_pin_oe = enable_ff & pin_en_ff;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pin_ff <= 1'b0;
		end
		else
		begin
			pin_ff <= nxt_pin;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pin_oe_ff <= 1'b0;
		end
		else
		begin
			pin_oe_ff <= nxt_pin_oe;
		end
	end

	assign comparator_out_pin    = pin_ff;
	assign comparator_out_pin_oe = pin_oe_ff;

	// Request also serves as the wakeup from wait and stop.
	assign irq = flag_ff & irq_en_ff;

	assign cmp_power_en = enable_ff;
	assign bandgap_sel  = enable_ff & ref_sel_ff;
	assign pos_pin_sel  = enable_ff & ~ref_sel_ff;
	assign neg_pin_sel  = 1'b1;

	always_comb
	begin
		csr_view                              = 8'h00;
		csr_view[acc_pkg::ENABLE_BIT]         = enable_ff;
		csr_view[acc_pkg::REF_SEL_BIT]        = ref_sel_ff;
		csr_view[acc_pkg::FLAG_BIT]           = flag_ff;
		csr_view[acc_pkg::IRQ_EN_BIT]         = irq_en_ff;
		csr_view[acc_pkg::READBACK_BIT]       = sync2_ff & enable_ff;
		csr_view[acc_pkg::PIN_EN_BIT]         = pin_en_ff;
		csr_view[acc_pkg::EDGE_SEL_MSB:acc_pkg::EDGE_SEL_LSB] = edge_sel_ff;
	end

	// Read data is captured in the setup cycle so it is stable in the access
	// phase; any other setup cycle clears it so stale data never reappears.
	always_comb
	begin
		nxt_prdata = prdata_ff;
		if (setup_rd)
			nxt_prdata = {24'h00_0000, csr_view};
		else if (setup_any)
			nxt_prdata = 32'h0000_0000;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_ff <= 32'h0000_0000;
		end
		else
		begin
			prdata_ff <= nxt_prdata;
		end
	end

endmodule : acc_comparator_ctrl

// ==== acc_core_model.sv ====
// Purpose: Behavioural analog comparator core with its input pins.
// Assumes: Levels are unsigned codes standing for voltages.
// Notes:   Unpowered, the output rests low like an idle comparator.
`timescale 1ns/10ps
module acc_core_model
(
	input  wire logic       pclk,    // Clock
	input  wire logic       power,   // Core power
	input  wire logic       bg_sel,  // Bandgap chosen
	input  wire logic       neg_sel, // Inverting pin connected
	input  wire logic [7:0] pos_lvl, // Positive pin
	input  wire logic [7:0] neg_lvl, // Negative pin
	input  wire logic [7:0] bg_lvl,  // Bandgap level
	output logic            result   // Raw result
);
	logic [7:0] inv;
	assign inv = neg_sel ? neg_lvl : 8'h00;
	assign result = power ? ((bg_sel ? bg_lvl : pos_lvl) > inv) : 1'b0;
endmodule : acc_core_model

// ==== acc_chk.sv ====
// Purpose: Port checker for the comparator control block.
// Assumes: One clock domain; the raw result passes two sync stages.
// Notes:   Pin and flag lag the raw result by three edges.
`timescale 1ns/10ps
module acc_chk
(
	input wire logic        pclk,                  // Clock
	input wire logic        presetn,               // Reset
	input wire logic        psel,                  // Select
	input wire logic        penable,               // Access
	input wire logic        pwrite,                // Write
	input wire logic [11:0] paddr,                 // Address
	input wire logic [31:0] prdata,                // Read data
	input wire logic        cmp_result_async,      // Raw result
	input wire logic        cmp_power_en,          // Core power
	input wire logic        comparator_out_pin,    // Pin
	input wire logic        comparator_out_pin_oe, // Pin enable
	input wire logic        irq                    // Request
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence rd_acc; psel && penable && !pwrite && paddr == 12'h000; endsequence
	sequence pin_held; comparator_out_pin_oe[*4]; endsequence
	AST_OE_NEEDS_EN: assert property (comparator_out_pin_oe |-> $past(cmp_power_en))
		else $error("pin enabled while off");
	AST_PIN_QUIET: assert property (!comparator_out_pin_oe |-> !comparator_out_pin)
		else $error("pin driven while not enabled");
	AST_PIN_FOLLOW: assert property (pin_held |-> comparator_out_pin == $past(cmp_result_async, 3))
		else $error("pin lags result wrongly");
	AST_RB_OFF: assert property (rd_acc ##0 !$past(cmp_power_en) |-> !prdata[3])
		else $error("readback set while off");
	AST_RB_LIVE: assert property (cmp_power_en[*4] ##0 rd_acc |-> prdata[3] == $past(cmp_result_async, 3))
		else $error("readback wrong");
	AST_IRQ_CAUSE: assert property ($rose(irq) |-> $past(psel && penable && pwrite) || $past(cmp_result_async, 3) != $past(cmp_result_async, 4))
		else $error("request without cause");
	AST_IRQ_EN: assert property ($rose(irq) && !$past(psel && penable && pwrite) |-> $past(cmp_power_en))
		else $error("event while off");
	AST_IRQ_HOLD: assert property ($fell(irq) |-> $past(psel && penable && pwrite))
		else $error("request dropped by itself");
endmodule : acc_chk
bind acc_comparator_ctrl acc_chk chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
	.prdata, .cmp_result_async, .cmp_power_en, .comparator_out_pin, .comparator_out_pin_oe, .irq);

// ==== tb.sv ====
// Purpose: Self-checking bench for the comparator control block.
// Assumes: Result needs three edges to reach flag, pin and readback.
// Notes:   Fixed waits of five edges cover that latency with margin.
`timescale 1ns/10ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errors++; \
	$display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module tb;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, q;
	logic [7:0]  pos = 8'h0a, neg = 8'h14, bg = 8'h32;
	logic        pready, pslverr, cmp_result_async, cmp_power_en, bandgap_sel, pos_pin_sel, e;
	logic        neg_pin_sel, comparator_out_pin, comparator_out_pin_oe, irq;
	int          errors = 0, compares = 0, cyc = 0;
	always #10 pclk = ~pclk;
	acc_comparator_ctrl dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .cmp_result_async, .cmp_power_en, .bandgap_sel,
		.pos_pin_sel, .neg_pin_sel, .comparator_out_pin, .comparator_out_pin_oe, .irq);
	acc_core_model core_u (.pclk, .power(cmp_power_en), .bg_sel(bandgap_sel),
		.neg_sel(neg_pin_sel), .pos_lvl(pos), .neg_lvl(neg), .bg_lvl(bg), .result(cmp_result_async));
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= {24'h00_0000, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata; e = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask : apb
	task automatic rd(input logic [7:0] x);
		apb(1'b0, 12'h000, 8'h00);
		`CHK(q, {24'h00_0000, x})
		`CHK({e, pready}, 2'b01)
	endtask : rd
	task automatic complete_run();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : complete_run
	always @(posedge pclk)
		if (++cyc == 5000)
		begin
			errors++;
			complete_run();
		end
	initial
	begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rd(8'h00);
		`CHK(neg_pin_sel, 1'b1)
		for (int m = 0; m < 4; m++)
		begin
			apb(1'b1, 12'h000, 8'hb0 | m[7:0]);
			@(posedge pclk); pos <= 8'h1e;
			repeat (5) @(posedge pclk);
			`CHK(irq, m[0])
			rd(8'h98 | m[7:0] | (m[0] ? 8'h20 : 8'h00));
			apb(1'b1, 12'h000, 8'hb0 | m[7:0]);
			@(posedge pclk); pos <= 8'h0a;
			repeat (5) @(posedge pclk);
			rd(8'h90 | m[7:0] | (m != 1 ? 8'h20 : 8'h00));
			$display("edge mode %0d done", m);
		end
		apb(1'b1, 12'h000, 8'he0);
		repeat (5) @(posedge pclk);
		`CHK({bandgap_sel, pos_pin_sel}, 2'b10)
		rd(8'hc8);
		apb(1'b1, 12'h000, 8'h84);
		repeat (4) @(posedge pclk); pos <= 8'h1e;
		repeat (5) @(posedge pclk);
		`CHK({comparator_out_pin_oe, comparator_out_pin}, 2'b11)
		rd(8'hac);
		apb(1'b1, 12'h000, 8'h04);
		repeat (2) @(posedge pclk);
		`CHK({cmp_power_en, comparator_out_pin_oe, comparator_out_pin, irq}, 4'h0)
		rd(8'h24);
		apb(1'b1, 12'h004, 8'hff);
		`CHK(e, 1'b1)
		rd(8'h24);
		$display("select, pin and disable done");
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd(8'h00);
		$display("second reset done");
		complete_run();
	end
endmodule : tb
